// ### logic/hmbs_pkg.sv
package hmbs_pkg;

    // ------------------------------------------------------------------
    // Command codes of the microprocessor port
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_IDENT_RD = 8'h27;
    localparam logic [7:0] CMD_SCRATCH_RD = 8'h28;
    localparam logic [7:0] CMD_SCRATCH_WR = 8'ha8;
    localparam logic [7:0] CMD_SOFT_RESET_WR = 8'ha9;
    localparam logic [7:0] CMD_BUF_STAT_RD = 8'h2c;
    localparam logic [7:0] CMD_BUF_STAT_WR = 8'hac;

    // ------------------------------------------------------------------
    // Values and widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam logic [15:0] RESET_COMMAND_VALUE = 16'h00f6;
    localparam logic [15:0] SCRATCH_RESET = 16'h0000;
    localparam logic [15:0] IDENT_DEFAULT = 16'h5a01; // Arbitrary value, replace per product.
    localparam int SYNC_W = DATA_W + 4;

    // ------------------------------------------------------------------
    // Field positions of the buffer status and control word
    // ------------------------------------------------------------------
    localparam int BIT_ISO_A_ENABLE = 0;
    localparam int BIT_ISO_B_ENABLE = 1;
    localparam int BIT_POLL_LIST_ENABLE = 2;
    localparam int BIT_ASYNC_LIST_ENABLE = 3;
    localparam int BIT_PAIR_TOGGLE_CLEAR = 4;
    localparam int BIT_ISO_A_IN_USE = 5;
    localparam int BIT_ISO_B_IN_USE = 6;
    localparam int BIT_ISO_A_CONSUMED = 8;
    localparam int BIT_ISO_B_CONSUMED = 9;
    localparam int BIT_PAIR_TOGGLE_STATE = 10;
    localparam logic [3:0] ENABLES_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HMBS_ST_WAIT_CMD = 2'b01,
        HMBS_ST_DATA = 2'b10
    } hmbs_state_e;

    // Status reported by the host engine, all on the local clock.
    typedef struct packed {
        logic pair_flip;
        logic iso_b_consumed;
        logic iso_a_consumed;
        logic iso_b_in_use;
        logic iso_a_in_use;
    } hmbs_engine_s;

    // Buffer enables handed to the host engine.
    typedef struct packed {
        logic async_list_enable;
        logic poll_list_enable;
        logic iso_b_enable;
        logic iso_a_enable;
    } hmbs_enable_s;

endpackage

// ### logic/hmbs_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for the asynchronous microprocessor pins.
module hmbs_sync
    import hmbs_pkg::*;
#(
    parameter int WIDTH = SYNC_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    // The first stage feeds only the second, so no logic sees a metastable value.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta[g] <= RESET_VALUE[g];
                    sync_o[g] <= RESET_VALUE[g];
                end else begin
                    meta[g] <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### logic/hmbs_flags.sv
`timescale 1ns/1ps
`default_nettype none

// Bank of sticky flags: hardware sets, a clear request empties.
module hmbs_flags
    import hmbs_pkg::*;
#(
    parameter int N = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] set_i,
    input wire logic [N-1:0] clr_i,
    output logic [N-1:0] flag_o
);

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    // A set in the same cycle as a clear wins, so no completion is lost.
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_flag
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    flag_o[g] <= 1'b0;
                end else if (set_i[g]) begin
                    flag_o[g] <= 1'b1;
                end else if (clr_i[g]) begin
                    flag_o[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### logic/hmbs_regs.sv
`timescale 1ns/1ps
`default_nettype none

module hmbs_regs
    import hmbs_pkg::*;
#(
    parameter logic [15:0] IDENTIFICATION_VALUE = IDENT_DEFAULT // Arbitrary value.
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic cmd_sel_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    input wire hmbs_engine_s engine_i,
    input wire logic iso_a_release_i,
    input wire logic iso_b_release_i,
    output hmbs_enable_s enable_o,
    output logic pair_toggle_state_o,
    output logic soft_reset_o
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    localparam logic [SYNC_W-1:0] PIN_IDLE = {4'hf, 16'h0000};

    logic [SYNC_W-1:0] pins_sync;
    logic cs_n_s;
    logic cmd_sel_s;
    logic wr_n_s;
    logic rd_n_s;
    logic [15:0] data_s;
    logic wr_n_d;
    logic rd_n_d;
    logic cs_n_d;

    // Idle levels at reset keep the edge detectors from firing at release.
    hmbs_sync #(
        .WIDTH(SYNC_W),
        .RESET_VALUE(PIN_IDLE)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({cs_n_i, 1'b0, wr_n_i, rd_n_i, data_i} | {1'b0, cmd_sel_i, 18'h00000}),
        .sync_o(pins_sync)
    );

    // Unpack the synchronised pins.
    assign cs_n_s = pins_sync[19];
    assign cmd_sel_s = pins_sync[18];
    assign wr_n_s = pins_sync[17];
    assign rd_n_s = pins_sync[16];
    assign data_s = pins_sync[15:0];

    // Previous samples for strobe edge detection.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_n_d <= 1'b1;
            rd_n_d <= 1'b1;
            cs_n_d <= 1'b1;
        end else begin
            wr_n_d <= wr_n_s;
            rd_n_d <= rd_n_s;
            cs_n_d <= cs_n_s;
        end
    end

    // ------------------------------------------------------------------
    // Strobe decoding
    // ------------------------------------------------------------------
    logic wr_done;
    logic rd_start;
    logic rd_active;
    logic cmd_write;
    logic data_write;
    logic data_read;

    // A write is taken at the end of its strobe, when the data has settled.
    assign wr_done = wr_n_s && !wr_n_d && !cs_n_d;
    assign rd_start = !rd_n_s && rd_n_d && !cs_n_s;
    assign rd_active = !rd_n_s && !cs_n_s;
    assign cmd_write = wr_done && cmd_sel_s;
    assign data_write = wr_done && !cmd_sel_s;
    assign data_read = rd_start && !cmd_sel_s;

    // ------------------------------------------------------------------
    // Command phase sequencer
    // ------------------------------------------------------------------
    hmbs_state_e state;
    hmbs_state_e next_state;
    logic [7:0] command;
    logic [7:0] next_command;

    // A data phase only follows a command; a new command always restarts.
    always_comb begin
        next_state = state;
        next_command = command;
        unique case (state)
            HMBS_ST_WAIT_CMD: begin
                if (cmd_write) begin
                    next_state = HMBS_ST_DATA;
                    next_command = data_s[7:0];
                end
            end
            HMBS_ST_DATA: begin
                if (cmd_write) begin
                    next_command = data_s[7:0];
                end else if (data_write || data_read) begin
                    next_state = HMBS_ST_WAIT_CMD;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= HMBS_ST_WAIT_CMD;
            command <= 8'h00;
        end else begin
            state <= next_state;
            command <= next_command;
        end
    end

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    logic in_data;
    logic scratch_wr;
    logic reset_wr;
    logic buf_wr;
    logic soft_reset_hit;

    assign in_data = (state == HMBS_ST_DATA);
    assign scratch_wr = in_data && data_write && (command == CMD_SCRATCH_WR);
    assign reset_wr = in_data && data_write && (command == CMD_SOFT_RESET_WR);
    assign buf_wr = in_data && data_write && (command == CMD_BUF_STAT_WR);
    // Any value other than the reset value leaves every register alone.
    assign soft_reset_hit = reset_wr && (data_s == RESET_COMMAND_VALUE);

    // ------------------------------------------------------------------
    // Scratch word
    // ------------------------------------------------------------------
    logic [15:0] scratch;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scratch <= SCRATCH_RESET;
        end else if (soft_reset_hit) begin
            scratch <= SCRATCH_RESET;
        end else if (scratch_wr) begin
            scratch <= data_s;
        end
    end

    // ------------------------------------------------------------------
    // Buffer enables and pair toggle clear bit
    // ------------------------------------------------------------------
    logic [3:0] enables;
    logic toggle_clear_bit;
    logic toggle_clear_rise;

    // Bit 4 is stored so that only a written 0-to-1 change has an effect.
    assign toggle_clear_rise = buf_wr && data_s[BIT_PAIR_TOGGLE_CLEAR] && !toggle_clear_bit;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enables <= ENABLES_RESET;
            toggle_clear_bit <= 1'b0;
        end else if (soft_reset_hit) begin
            enables <= ENABLES_RESET;
            toggle_clear_bit <= 1'b0;
        end else if (buf_wr) begin
            enables <= data_s[BIT_ASYNC_LIST_ENABLE:BIT_ISO_A_ENABLE];
            toggle_clear_bit <= data_s[BIT_PAIR_TOGGLE_CLEAR];
        end
    end

    // ------------------------------------------------------------------
    // Pair toggle state
    // ------------------------------------------------------------------
    // The clear is judged against the stored async enable, not the value
    // written alongside it, so a running list is never disturbed.
    logic pair_toggle;
    logic toggle_clear_ok;

    assign toggle_clear_ok = toggle_clear_rise && !enables[BIT_ASYNC_LIST_ENABLE];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pair_toggle <= 1'b0;
        end else if (soft_reset_hit || toggle_clear_ok) begin
            pair_toggle <= 1'b0;
        end else if (engine_i.pair_flip) begin
            pair_toggle <= !pair_toggle;
        end
    end

    // ------------------------------------------------------------------
    // Consumed flags of the iso buffers
    // ------------------------------------------------------------------
    logic [1:0] consumed;
    logic [1:0] consumed_clr;

    // A flag empties when the engine releases the buffer, when software
    // drops the buffer's enable, or on a software reset.
    assign consumed_clr[0] = iso_a_release_i || soft_reset_hit || (buf_wr && !data_s[BIT_ISO_A_ENABLE]);
    assign consumed_clr[1] = iso_b_release_i || soft_reset_hit || (buf_wr && !data_s[BIT_ISO_B_ENABLE]);

    hmbs_flags #(
        .N(2)
    ) u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i({engine_i.iso_b_consumed, engine_i.iso_a_consumed}),
        .clr_i(consumed_clr),
        .flag_o(consumed)
    );

    // ------------------------------------------------------------------
    // Buffer status word assembly
    // ------------------------------------------------------------------
    logic [15:0] buf_status;

    // Unlisted bits stay zero, covering the reserved positions.
    always_comb begin
        buf_status = 16'h0000;
        buf_status[BIT_PAIR_TOGGLE_STATE] = pair_toggle;
        buf_status[BIT_ISO_B_CONSUMED] = consumed[1];
        buf_status[BIT_ISO_A_CONSUMED] = consumed[0];
        buf_status[BIT_ISO_B_IN_USE] = engine_i.iso_b_in_use;
        buf_status[BIT_ISO_A_IN_USE] = engine_i.iso_a_in_use;
        buf_status[BIT_PAIR_TOGGLE_CLEAR] = toggle_clear_bit;
        buf_status[BIT_ASYNC_LIST_ENABLE:BIT_ISO_A_ENABLE] = enables;
    end

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    logic [15:0] read_value;

    // Unknown and write-only codes read as zero.
    assign read_value = (command == CMD_IDENT_RD) ? IDENTIFICATION_VALUE :
                        (command == CMD_SCRATCH_RD) ? scratch :
                        (command == CMD_BUF_STAT_RD) ? buf_status :
                        16'h0000;

    // ------------------------------------------------------------------
    // Data bus drive
    // ------------------------------------------------------------------
    // The word is captured once at the start of the read so it stays
    // stable for the whole strobe even if the status moves meanwhile.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 16'h0000;
            data_oe_o <= 1'b0;
        end else begin
            if (in_data && data_read) begin
                data_o <= read_value;
                data_oe_o <= 1'b1;
            end else if (!rd_active) begin
                data_oe_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs to the host engine
    // ------------------------------------------------------------------
    // The reset pulse lets the rest of the engine and the dual role logic
    // return to reset; the buffer memory must not be wired to it.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_o <= '0;
            pair_toggle_state_o <= 1'b0;
            soft_reset_o <= 1'b0;
        end else begin
            enable_o <= hmbs_enable_s'(next_enables_view(enables, buf_wr, soft_reset_hit, data_s));
            pair_toggle_state_o <= next_toggle_view(pair_toggle, soft_reset_hit || toggle_clear_ok,
                                                    engine_i.pair_flip);
            soft_reset_o <= soft_reset_hit;
        end
    end

    // Next value of the enables, so the engine sees them with the register.
    function automatic logic [3:0] next_enables_view(input logic [3:0] cur, input logic wr,
                                                     input logic srst, input logic [15:0] d);
        logic [3:0] v;
        v = cur;
        if (srst) begin
            v = ENABLES_RESET;
        end else if (wr) begin
            v = d[BIT_ASYNC_LIST_ENABLE:BIT_ISO_A_ENABLE];
        end
        return v;
    endfunction

    // Next value of the pair toggle, mirroring the toggle register.
    function automatic logic next_toggle_view(input logic cur, input logic clr, input logic flip);
        logic v;
        v = cur;
        if (clr) begin
            v = 1'b0;
        end else if (flip) begin
            v = !cur;
        end
        return v;
    endfunction

endmodule

`default_nettype wire

// ### verification/hmbs_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the pins of the register bank; strobe pins are counted idle because commits lag the pins.
module hmbs_regs_asserts
    import hmbs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic cmd_sel_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    input wire logic [15:0] data_o,
    input wire logic data_oe_o,
    input wire hmbs_engine_s engine_i,
    input wire hmbs_enable_s enable_o,
    input wire logic pair_toggle_state_o,
    input wire logic soft_reset_o
);
    // ------------------------------------------------------------------
    // Idle counters
    // ------------------------------------------------------------------
    logic [3:0] wr_idle;
    logic [3:0] rd_idle;

    // Saturating counts of cycles since each strobe pin was last low.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_idle <= 4'h0;
            rd_idle <= 4'h0;
        end else begin
            wr_idle <= !wr_n_i ? 4'h0 : ((wr_idle == 4'hf) ? wr_idle : wr_idle + 4'h1);
            rd_idle <= !rd_n_i ? 4'h0 : ((rd_idle == 4'hf) ? rd_idle : rd_idle + 4'h1);
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_oe_cause; $rose(data_oe_o) |-> (!rd_n_i && !cs_n_i && !cmd_sel_i); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("data driven without a read");
    property p_rd_latency; $fell(rd_n_i) && !cs_n_i && !cmd_sel_i |-> ##[2:6] data_oe_o; endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read not answered in time");
    property p_oe_release; rd_idle >= 4'h5 |-> !data_oe_o; endproperty
    a_oe_release: assert property (p_oe_release) else $error("data bus not released");
    property p_data_hold; !data_oe_o |=> ($stable(data_o) || data_oe_o); endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved without a read");
    property p_enable_hold; wr_idle >= 4'ha |=> $stable(enable_o); endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enables moved without a write");
    property p_toggle_hold; wr_idle >= 4'ha && !engine_i.pair_flip |=> $stable(pair_toggle_state_o); endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("pair toggle moved by itself");
    property p_toggle_flip;
        wr_idle >= 4'ha && engine_i.pair_flip |=> pair_toggle_state_o != $past(pair_toggle_state_o);
    endproperty
    a_toggle_flip: assert property (p_toggle_flip) else $error("pair toggle missed a flip");
    property p_srst_pulse; soft_reset_o |=> !soft_reset_o; endproperty
    a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse too long");
    property p_srst_cause; soft_reset_o |-> (wr_idle >= 4'h1 && wr_idle <= 4'h7); endproperty
    a_srst_cause: assert property (p_srst_cause) else $error("soft reset without a write");
    property p_srst_clear; soft_reset_o |-> ##[0:2] (enable_o == 4'h0 && !pair_toggle_state_o); endproperty
    a_srst_clear: assert property (p_srst_clear) else $error("soft reset left state set");
endmodule

`default_nettype wire

// ### verification/hmbs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Microprocessor side of the command-code port; all pins move at falling edges.
module hmbs_host_model
    import hmbs_pkg::*;
(
    input wire logic clk_i,
    output logic cs_n_o,
    output logic cmd_sel_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic [15:0] data_o
);
    // Idle bus at time zero.
    initial begin
        cs_n_o = 1'b1;
        cmd_sel_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        data_o = 16'h0000;
    end

    // One strobed word. The bus shows the inverse once its hold ends, so a stale word never looks valid.
    task automatic put_word(input logic cmd, input logic [15:0] w);
        @(negedge clk_i);
        cmd_sel_o = cmd;
        data_o = w;
        wr_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        wr_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
        data_o = ~w;
        repeat (4) @(negedge clk_i);
    endtask

    // Command then one data word, chip selected throughout.
    task automatic reg_write(input logic [7:0] cmd, input logic [15:0] w);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        put_word(1'b1, {8'h00, cmd});
        put_word(1'b0, w);
        cs_n_o = 1'b1;
    endtask

    // Command then a read strobe held long enough for the synchronised answer.
    task automatic reg_read(input logic [7:0] cmd);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        put_word(1'b1, {8'h00, cmd});
        cmd_sel_o = 1'b0;
        @(negedge clk_i);
        rd_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        rd_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask

    // The driver resets the engine through the write-only reset register.
    task automatic soft_reset(input logic [15:0] v);
        reg_write(CMD_SOFT_RESET_WR, v);
    endtask
endmodule

`default_nettype wire

// ### verification/test_host_misc_and_buffer_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_host_misc_and_buffer_status_regs
    import hmbs_pkg::*;
;
    logic clk_i, rst_i, cs_n, cmd_sel, wr_n, rd_n, data_oe_o, toggle, srst, rel_a, rel_b, oe_d;
    logic [15:0] bus_d, data_o, w;
    logic [7:0] lfsr;
    hmbs_engine_s eng;
    hmbs_enable_s enable_o;
    int n_mismatch, tests_run, n_srst;
    logic [15:0] exp_q[$];
    logic [15:0] en_tab[3] = '{16'h0005, 16'h000a, 16'h000f};
    logic [15:0] bad_tab[3] = '{16'h00f5, 16'h01f6, 16'hf600};

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    hmbs_host_model i_hmbs_host_model (.clk_i(clk_i), .cs_n_o(cs_n), .cmd_sel_o(cmd_sel), .wr_n_o(wr_n),
        .rd_n_o(rd_n), .data_o(bus_d));
    hmbs_regs i_hmbs_regs (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .cmd_sel_i(cmd_sel), .wr_n_i(wr_n),
        .rd_n_i(rd_n), .data_i(bus_d), .data_o(data_o), .data_oe_o(data_oe_o), .engine_i(eng),
        .iso_a_release_i(rel_a), .iso_b_release_i(rel_b), .enable_o(enable_o),
        .pair_toggle_state_o(toggle), .soft_reset_o(srst));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A read notes its expectation; the monitor below judges the answer, an empty queue proves one came.
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        exp_q.push_back(exp);
        i_hmbs_host_model.reg_read(cmd);
        check(16'(exp_q.size()), 16'h0000);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
        i_hmbs_host_model.reg_write(cmd, v);
    endtask

    // Engine pulses come well after any write so that they never meet a commit.
    task automatic eng_pulse(input logic [4:0] m);
        repeat (10) @(negedge clk_i);
        eng = hmbs_engine_s'(eng | m);
        @(negedge clk_i);
        eng = hmbs_engine_s'(eng & ~m);
        repeat (2) @(negedge clk_i);
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Monitors and watchdog
    // ------------------------------------------------------------------
    // Each rise of the output enable is one answer; it takes the oldest expectation.
    always @(negedge clk_i) begin
        if (data_oe_o === 1'b1 && oe_d !== 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("wrong value at %0t: unrequested read answer", $time);
            end else begin
                check(data_o, exp_q.pop_front());
            end
        end
        oe_d = data_oe_o;
    end

    always @(posedge clk_i) begin
        if (srst === 1'b1) begin
            n_srst++;
        end
    end

    // The sequence needs about a thousand cycles; twenty thousand means a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("wrong value at %0t: run did not finish", $time);
        report_and_stop;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        eng = '0;
        rel_a = 1'b0;
        rel_b = 1'b0;
        lfsr = 8'd45;
        n_mismatch = 0;
        tests_run = 0;
        n_srst = 0;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        rd(CMD_IDENT_RD, IDENT_DEFAULT);
        rd(CMD_SCRATCH_RD, SCRATCH_RESET);
        rd(CMD_BUF_STAT_RD, 16'h0000);
        rd(8'h55, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            w = {lfsr, ~lfsr};
            wr(CMD_SCRATCH_WR, w);
            rd(CMD_SCRATCH_RD, w);
        end
        wr(CMD_BUF_STAT_WR, 16'hffef);
        rd(CMD_BUF_STAT_RD, 16'h000f);
        foreach (en_tab[k]) begin
            wr(CMD_BUF_STAT_WR, en_tab[k]);
            check(16'(enable_o), en_tab[k]);
        end
        eng_pulse(5'b10000);
        check(16'(toggle), 16'h0001);
        rd(CMD_BUF_STAT_RD, 16'h040f);
        wr(CMD_BUF_STAT_WR, 16'h001f);
        rd(CMD_BUF_STAT_RD, 16'h041f);
        wr(CMD_BUF_STAT_WR, 16'h0007);
        wr(CMD_BUF_STAT_WR, 16'h0017);
        rd(CMD_BUF_STAT_RD, 16'h0017);
        eng = hmbs_engine_s'(5'b00011);
        eng_pulse(5'b01100);
        rd(CMD_BUF_STAT_RD, 16'h0377);
        @(negedge clk_i);
        rel_a = 1'b1;
        @(negedge clk_i);
        rel_a = 1'b0;
        rd(CMD_BUF_STAT_RD, 16'h0277);
        eng = '0;
        rel_b = 1'b1;
        @(negedge clk_i);
        rel_b = 1'b0;
        rd(CMD_BUF_STAT_RD, 16'h0017);
        // Dropping the second iso enable must also empty its consumed flag.
        eng_pulse(5'b01000);
        wr(CMD_BUF_STAT_WR, 16'h0015);
        check(16'(enable_o), 16'h0005);
        rd(CMD_BUF_STAT_RD, 16'h0015);
        wr(CMD_SCRATCH_WR, 16'hbeef);
        eng_pulse(5'b10000);
        foreach (bad_tab[k]) begin
            i_hmbs_host_model.soft_reset(bad_tab[k]);
            rd(CMD_SCRATCH_RD, 16'hbeef);
        end
        check(16'(n_srst), 16'h0000);
        i_hmbs_host_model.soft_reset(RESET_COMMAND_VALUE);
        check(16'(n_srst), 16'h0001);
        rd(CMD_SCRATCH_RD, SCRATCH_RESET);
        rd(CMD_BUF_STAT_RD, 16'h0000);
        report_and_stop;
    end
endmodule

bind hmbs_regs hmbs_regs_asserts i_hmbs_regs_asserts (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
    .cmd_sel_i(cmd_sel_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .engine_i(engine_i), .enable_o(enable_o), .pair_toggle_state_o(pair_toggle_state_o),
    .soft_reset_o(soft_reset_o));

`default_nettype wire
